/* shared/febs_regs.svh */
// Purpose: Offsets, reset values and field constants of the erase block select
// Assumes: Included by design and verification files
// Notes:   Register indices are printed offsets; byte address is four times index
`ifndef FEBS_REGS_SVH
`define FEBS_REGS_SVH

`define FEBS_LARGE_IDX      8'h42
`define FEBS_SMALL_IDX      8'h43
`define FEBS_LARGE_ADDR     12'h108
`define FEBS_SMALL_ADDR     12'h10c
`define FEBS_MODE_ADDR      12'h110
`define FEBS_SEL_RESET      8'h00
`define FEBS_SEL_LOCKED     8'hff
`define FEBS_MODE_FLASH_MIN 3'h5
`define FEBS_MODE_RESET     3'h0
`define FEBS_LOCK_RESET     1'h1
`define FEBS_RDATA_RESET    32'h0000_0000

`endif

/* shared/febs_pkg.sv */
// Purpose: Types for the erase block select block
// Assumes: Header febs_regs.svh holds numbers
// Notes:   None
package febs_pkg;
   typedef logic [7:0] febs_sel_t;
   typedef struct packed {
      febs_sel_t large_block_pick_bits;
      febs_sel_t small_block_pick_bits;
   } febs_mask_s;
   typedef enum logic [1:0] {
      FEBS_IDLE,
      FEBS_ACCESS
   } febs_phase_e;
endpackage : febs_pkg

/* design/febs_sel_reg.sv */
// Purpose: One 8-bit erase select register with mode lock
// Assumes: Write strobe qualified by the bus slave
// Notes:   Reads as all ones while locked
`timescale 1ns/1ps
`include "febs_regs.svh"
module febs_sel_reg (
   input  wire logic              clk_i,     // System clock
   input  wire logic              nrst_i,    // Async reset, low
   input  wire logic              locked_i,  // Flash disabled by mode
   input  wire logic              wr_i,      // Write strobe
   input  wire febs_pkg::febs_sel_t wdata_i, // Write data
   output febs_pkg::febs_sel_t    value_o,   // Stored selection
   output febs_pkg::febs_sel_t    rdata_o    // Read view
);
   import febs_pkg::*;

   febs_sel_t sel;
   febs_sel_t next_sel;

   always_comb begin
      next_sel = sel;
      if (wr_i && !locked_i) begin   // RULE4
         next_sel = wdata_i;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sel <= `FEBS_SEL_RESET;      // RULE3
      end else begin
         sel <= next_sel;
      end
   end

   assign value_o = sel;
   assign rdata_o = locked_i ? `FEBS_SEL_LOCKED : sel;  // RULE5
endmodule : febs_sel_reg

/* design/febs_top.sv */
// Purpose: APB slave holding the flash erase large and small block selects
// Assumes: Mode pins static, synchronised here before use
// Notes:   Zero wait states; unmapped addresses answer pslverr
//
// Overview of operation
// (RULE1) Each large-select bit set to one picks that large block for erase.
// (RULE2) Each small-select bit set to one picks that small block for erase.
// (RULE3) With flash enabled by mode five to seven both selects reset to zero.
// (RULE4) With flash disabled by mode zero to four writes to both selects are ignored.
// (RULE5) With flash disabled both selects always read as all ones.
// (RULE6) The sixteen select bits go to the erase logic as one block mask; the code sends an all-zero mask while flash is disabled.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "febs_regs.svh"
module febs_top #(
   parameter int NUM_LARGE = 8,  // Large blocks served
   parameter int NUM_SMALL = 8   // Small blocks served
) (
   input  wire logic         clk_i,     // 125 MHz system clock
   input  wire logic         nrst_i,    // Async reset, low
   input  wire logic [2:0]   mode_i,    // Operating mode pins
   input  wire logic         psel,      // APB select
   input  wire logic         penable,   // APB enable
   input  wire logic         pwrite,    // APB direction
   input  wire logic [11:0]  paddr,     // APB byte address
   input  wire logic [31:0]  pwdata,    // APB write data
   input  wire logic [3:0]   pstrb,     // APB byte strobes
   output logic              pready,    // APB ready
   output logic [31:0]       prdata,    // APB read data
   output logic              pslverr,   // APB error
   output febs_pkg::febs_mask_s erase_mask_o, // Block mask to eraser
   output logic              flash_locked_o // Flash disabled by mode
);
   import febs_pkg::*;

   // ----------------------------------------
   // Parameter checks
   // ----------------------------------------
   if (NUM_LARGE < 1 || NUM_LARGE > $bits(febs_sel_t)) begin : g_bad_large
      $error("NUM_LARGE must lie between one and the select width");
   end
   if (NUM_SMALL < 1 || NUM_SMALL > $bits(febs_sel_t)) begin : g_bad_small
      $error("NUM_SMALL must lie between one and the select width");
   end

   // ----------------------------------------
   // Mode synchroniser
   // ----------------------------------------
   logic [2:0] mode_meta;
   logic [2:0] mode_sync;
   logic       locked;
   logic       next_locked;

   always_comb begin
      next_locked = (mode_sync < `FEBS_MODE_FLASH_MIN);
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mode_meta <= `FEBS_MODE_RESET;
         mode_sync <= `FEBS_MODE_RESET;
         locked    <= `FEBS_LOCK_RESET;
      end else begin
         mode_meta <= mode_i;
         mode_sync <= mode_meta;
         locked    <= next_locked;
      end
   end

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
      hit = (a == r);
   endfunction : hit

   // Bits kept for a register serving n blocks
   function automatic febs_sel_t keep_bits(input int n);
      keep_bits = `FEBS_SEL_RESET;
      for (int i = 0; i < $bits(febs_sel_t); i++) begin
         if (i < n) begin
            keep_bits[i] = 1'b1;
         end
      end
   endfunction : keep_bits

   // What the eraser sees once this edge has passed
   function automatic febs_sel_t mask_view(input logic      lock_next,
                                           input logic      take,
                                           input febs_sel_t wdat,
                                           input febs_sel_t cur);
      mask_view = `FEBS_SEL_RESET;
      if (!lock_next) begin
         if (take) begin
            mask_view = wdat;
         end else begin
            mask_view = cur;
         end
      end
   endfunction : mask_view

   localparam int        NUM_SEL    = 2;
   localparam int        LARGE      = 0;
   localparam int        SMALL      = 1;
   localparam febs_sel_t LARGE_KEEP = keep_bits(NUM_LARGE);
   localparam febs_sel_t SMALL_KEEP = keep_bits(NUM_SMALL);

   logic        acc;
   logic        setup;
   logic        mapped;
   logic        hit_large;
   logic        hit_small;
   logic [31:0] read_word;
   logic [31:0] rdata_q;
   logic [31:0] next_rdata;
   febs_phase_e phase;
   febs_phase_e next_phase;
   logic        wr_sel   [NUM_SEL];
   febs_sel_t   wdat_sel [NUM_SEL];
   febs_sel_t   val_sel  [NUM_SEL];
   febs_sel_t   rd_sel   [NUM_SEL];
   febs_mask_s  mask_q;
   febs_mask_s  next_mask;

   assign acc    = psel && penable;
   assign setup  = psel && !penable;
   assign pready = 1'b1;

   always_comb begin
      mapped    = 1'b1;
      hit_large = 1'b0;
      hit_small = 1'b0;
      read_word = 32'h0;
      if (hit(paddr, `FEBS_LARGE_ADDR)) begin
         hit_large = 1'b1;
         read_word = {24'h0, rd_sel[LARGE]};
      end else if (hit(paddr, `FEBS_SMALL_ADDR)) begin
         hit_small = 1'b1;
         read_word = {24'h0, rd_sel[SMALL]};
      end else if (hit(paddr, `FEBS_MODE_ADDR)) begin
         read_word = {28'h0, locked, mode_sync};
      end else begin
         mapped = 1'b0;
      end
   end

   assign pslverr = acc && !mapped;

   // ----------------------------------------
   // Write strobes
   // ----------------------------------------
   // Bits above the served block count never store
   always_comb begin
      wr_sel[LARGE]   = acc && pwrite && pstrb[0] && hit_large;  // RULE1
      wr_sel[SMALL]   = acc && pwrite && pstrb[0] && hit_small;  // RULE2
      wdat_sel[LARGE] = pwdata[7:0] & LARGE_KEEP;
      wdat_sel[SMALL] = pwdata[7:0] & SMALL_KEEP;
   end

   // ----------------------------------------
   // Bus phase and read data
   // ----------------------------------------
   // Read word taken at end of setup, stands through access
   always_comb begin
      next_phase = phase;
      next_rdata = rdata_q;
      case (phase)
         FEBS_IDLE: begin
            if (setup) begin
               next_phase = FEBS_ACCESS;
               next_rdata = read_word;
            end
         end
         FEBS_ACCESS: begin
            if (setup) begin
               next_rdata = read_word;
            end else begin
               next_phase = FEBS_IDLE;
            end
         end
         default: begin
            next_phase = FEBS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         phase   <= FEBS_IDLE;
         rdata_q <= `FEBS_RDATA_RESET;
      end else begin
         phase   <= next_phase;
         rdata_q <= next_rdata;
      end
   end

   assign prdata = rdata_q;

   // ----------------------------------------
   // Select registers
   // ----------------------------------------
   for (genvar g = 0; g < NUM_SEL; g++) begin : g_sel
      febs_sel_reg u_sel (
         .clk_i    (clk_i),
         .nrst_i   (nrst_i),
         .locked_i (locked),
         .wr_i     (wr_sel[g]),
         .wdata_i  (wdat_sel[g]),
         .value_o  (val_sel[g]),
         .rdata_o  (rd_sel[g])
      );
   end

   // ----------------------------------------
   // Erase mask
   // ----------------------------------------
   // Follows the selects edge for edge; locked device selects nothing
   always_comb begin
      next_mask.large_block_pick_bits = mask_view(next_locked, wr_sel[LARGE] && !locked,
                                                  wdat_sel[LARGE], val_sel[LARGE]);  // RULE6
      next_mask.small_block_pick_bits = mask_view(next_locked, wr_sel[SMALL] && !locked,
                                                  wdat_sel[SMALL], val_sel[SMALL]);  // RULE6
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mask_q.large_block_pick_bits <= `FEBS_SEL_RESET;
         mask_q.small_block_pick_bits <= `FEBS_SEL_RESET;
      end else begin
         mask_q <= next_mask;
      end
   end

   assign erase_mask_o   = mask_q;
   assign flash_locked_o = locked;
endmodule : febs_top

/* dv/febs_checker.sv */
// Purpose: Port assertions of erase block select
// Assumes: Bound to febs_top
// Notes:   One clock domain
`timescale 1ns/1ps
`include "febs_regs.svh"
module febs_checker (
   input wire logic       clk_i, nrst_i, psel, penable, pwrite, flash_locked_o, // Watched
   input wire logic [11:0] paddr,                 // Address
   input wire logic [31:0] pwdata, prdata,         // Data
   input wire logic [3:0]  pstrb,                 // Strobes
   input wire febs_pkg::febs_mask_s erase_mask_o  // Mask
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   wire ul = !flash_locked_o;
   wire wl = psel & penable & pwrite & pstrb[0] & paddr == `FEBS_LARGE_ADDR;
   wire ws = psel & penable & pwrite & pstrb[0] & paddr == `FEBS_SMALL_ADDR;
   wire rs = psel & penable & !pwrite & (paddr == `FEBS_LARGE_ADDR | paddr == `FEBS_SMALL_ADDR);
   a_large_store: assert property (wl && ul |=> erase_mask_o[15:8] == $past(pwdata[7:0]))
      else $error("large not stored");
   a_small_store: assert property (ws && ul |=> erase_mask_o[7:0] == $past(pwdata[7:0]))
      else $error("small not stored");
   a_reset_zero: assert property ($rose(nrst_i) |-> (erase_mask_o == 16'h0) [*5])
      else $error("mask not zero");
   a_lock_keep: assert property ((wl || ws) && !ul |=> $stable(erase_mask_o))
      else $error("locked write stored");
   a_lock_read: assert property (rs && !ul |-> prdata == 32'h0000_00ff)
      else $error("locked read wrong");
   a_mask_lock: assert property (!ul |-> erase_mask_o == 16'h0)
      else $error("mask set while locked");
   c_store: cover property (wl && ul);
   c_lock_read: cover property (rs && !ul);
   c_unlock: cover property ($fell(flash_locked_o));
endmodule : febs_checker

/* dv/tb_top.sv */
// Purpose: Self-checking bench of erase block select
// Assumes: Zero to fifteen wait states
// Notes:   Directed stimulus only
`timescale 1ns/1ps
`include "febs_regs.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
   $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb_top;
   import febs_pkg::*;
   logic        clk_i = 0, nrst_i = 0, psel = 0, penable = 0, pwrite = 0;
   logic        pready, pslverr, lk, er;
   logic [2:0]  mode_i = 3'h3;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   febs_mask_s  msk;
   int          err_count = 0, checked = 0;
   always #4 clk_i = ~clk_i;
   febs_top i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .mode_i(mode_i), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .erase_mask_o(msk),
      .flash_locked_o(lk));
   task automatic end_of_test;
      $display("errors %0d checks %0d", err_count, checked);
      if (err_count == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test
   task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
      @(posedge clk_i);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
      @(posedge clk_i);
      penable <= 1;
      n = 0;
      do begin @(posedge clk_i); n++; end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin err_count++; end_of_test(); end
      rd = prdata; er = pslverr;
      psel <= 0; penable <= 0;
   endtask : bus
   task automatic set_mode(input logic [2:0] m);
      mode_i <= m;
      repeat (6) @(posedge clk_i);
   endtask : set_mode
   initial begin
      repeat (5) @(posedge clk_i);
      nrst_i <= 1;
      set_mode(3'h3); `CHK(lk, 1'b1)
      bus(0, `FEBS_LARGE_ADDR, 0); `CHK(rd, 32'h0000_00ff)
      bus(0, `FEBS_SMALL_ADDR, 0); `CHK(rd, 32'h0000_00ff)
      bus(1, `FEBS_LARGE_ADDR, 8'h5a);
      bus(1, `FEBS_SMALL_ADDR, 8'ha5);
      set_mode(3'h6); `CHK(lk, 1'b0)
      bus(0, `FEBS_LARGE_ADDR, 0); `CHK(rd, 32'h0)
      bus(0, `FEBS_SMALL_ADDR, 0); `CHK(rd, 32'h0)
      bus(1, `FEBS_LARGE_ADDR, 8'h81);
      bus(1, `FEBS_SMALL_ADDR, 8'h7e);
      bus(0, `FEBS_LARGE_ADDR, 0); `CHK(rd, 32'h81)
      bus(0, `FEBS_SMALL_ADDR, 0); `CHK(rd, 32'h7e)
      `CHK(msk, 16'h817e)
      bus(0, 12'h114, 0); `CHK(er, 1'b1)
      nrst_i <= 0;
      repeat (2) @(posedge clk_i);
      nrst_i <= 1;
      set_mode(3'h6); `CHK(msk, 16'h0)
      bus(0, `FEBS_LARGE_ADDR, 0); `CHK(rd, 32'h0)
      bus(0, `FEBS_SMALL_ADDR, 0); `CHK(rd, 32'h0)
      bus(1, `FEBS_LARGE_ADDR, 8'h3c);
      set_mode(3'h2); `CHK(lk, 1'b1)
      bus(0, `FEBS_LARGE_ADDR, 0); `CHK(rd, 32'h0000_00ff)
      bus(0, `FEBS_SMALL_ADDR, 0); `CHK(rd, 32'h0000_00ff)
      `CHK(msk, 16'h0)
      end_of_test();
   end
endmodule : tb_top
bind febs_top febs_checker i_chk (.clk_i(clk_i), .nrst_i(nrst_i), .psel(psel),
   .penable(penable), .pwrite(pwrite), .flash_locked_o(flash_locked_o), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pstrb(pstrb), .erase_mask_o(erase_mask_o));
